// ---- core/idc_regs.svh ----
`ifndef IDC_REGS_SVH
`define IDC_REGS_SVH

// ----------------------------------------------------------------
// register offsets (isa i/o window, low nibble)
// ----------------------------------------------------------------
`define IDC_OFF_CMD        4'h8
`define IDC_OFF_REQ        4'h9
`define IDC_OFF_SMASK      4'ha
`define IDC_OFF_MODE       4'hb
`define IDC_OFF_BPTR       4'hc
`define IDC_OFF_TEMP_CLR   4'hd
`define IDC_OFF_UNMASK     4'he
`define IDC_OFF_AMASK      4'hf

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IDC_CMD_COPY_BIT   0
`define IDC_CMD_HOLD_BIT   1
`define IDC_SETCLR_BIT     2
`define IDC_MODE_DIR_BIT   5
`define IDC_MODE_AUTO_BIT  4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IDC_RST_CMD        2'h0
`define IDC_RST_MASK       4'hf
`define IDC_RST_REQ        4'h0
`define IDC_RST_TEMP       8'h00

`endif

// ---- core/idc_pkg.sv ----
package idc_pkg;

    // channel service mode
    typedef enum logic [1:0] {
        IDC_DEMAND  = 2'b00,
        IDC_SINGLE  = 2'b01,
        IDC_BLOCK   = 2'b10,
        IDC_CASCADE = 2'b11
    } idc_mode_t;

    // transfer type
    typedef enum logic [1:0] {
        IDC_VERIFY  = 2'b00,
        IDC_WRITE   = 2'b01,
        IDC_READ    = 2'b10,
        IDC_ILLEGAL = 2'b11
    } idc_xfer_t;

    // controller state
    typedef enum logic [0:0] {
        IDC_IDLE   = 1'b0,
        IDC_ACTIVE = 1'b1
    } idc_state_t;

endpackage

// ---- core/idc_channel_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "idc_regs.svh"

module idc_channel_control #(
    parameter int NCH = 4
) (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ioWrite,
    input  wire logic                  ioRead,
    input  wire logic [3:0]            ioAddr,
    input  wire logic [7:0]            ioWdata,
    input  wire logic                  wordAccess,
    input  wire logic                  xferActive,
    input  wire logic                  copyByteValid,
    input  wire logic [7:0]            copyByte,
    input  wire logic [NCH-1:0]        dreqIn,
    output logic      [7:0]            ioRdata,
    output logic                       memoryCopyEnable,
    output logic                       channel0AddrHold,
    output logic      [NCH-1:0]        channelBlock,
    output logic      [NCH-1:0]        softRequest,
    output logic      [NCH-1:0]        requestPending,
    output idc_pkg::idc_mode_t [NCH-1:0] chanMode,
    output logic      [NCH-1:0]        addressDirection,
    output logic      [NCH-1:0]        autoInit,
    output idc_pkg::idc_xfer_t [NCH-1:0] transferType,
    output logic      [NCH-1:0]        typeValid,
    output logic                       highByteSel,
    output logic                       softResetStrobe,
    output idc_pkg::idc_state_t        ctrlState
);
    import idc_pkg::*;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    logic           wrCmd;     // command bits
    logic           wrReq;     // software request
    logic           wrSmask;   // one mask bit
    logic           wrMode;    // channel mode
    logic           wrBptr;    // byte flop clear
    logic           wrClr;     // master clear
    logic           wrUnmask;  // all masks off
    logic           wrAmask;   // all masks loaded
    logic [NCH-1:0] selOne;

    // write strobes per offset
    always_comb
    begin
        wrCmd    = ioWrite && hit(ioAddr, `IDC_OFF_CMD);
        wrReq    = ioWrite && hit(ioAddr, `IDC_OFF_REQ);
        wrSmask  = ioWrite && hit(ioAddr, `IDC_OFF_SMASK);
        wrMode   = ioWrite && hit(ioAddr, `IDC_OFF_MODE);
        wrBptr   = ioWrite && hit(ioAddr, `IDC_OFF_BPTR);
        wrClr    = ioWrite && hit(ioAddr, `IDC_OFF_TEMP_CLR);
        wrUnmask = ioWrite && hit(ioAddr, `IDC_OFF_UNMASK);
        wrAmask  = ioWrite && hit(ioAddr, `IDC_OFF_AMASK);
        selOne   = '0;
        selOne[ioWdata[1:0]] = 1'b1;
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    // command, masks and requests
    logic [1:0]        cmd_q, cmd_d;
    logic [NCH-1:0]    mask_q, mask_d;
    logic [NCH-1:0]    req_q, req_d;
    logic [NCH-1:0]    pend_q, pend_d;

    // per-channel mode
    idc_mode_t [NCH-1:0] mode_q, mode_d;
    logic [NCH-1:0]    dir_q, dir_d;
    logic [NCH-1:0]    auto_q, auto_d;
    logic [NCH-1:0]    tvalid_q, tvalid_d;
    idc_xfer_t [NCH-1:0] xfer_q, xfer_d;

    // byte flop, temporary byte, read data, strobe and state
    logic              bptr_q, bptr_d;
    logic [7:0]        temp_q, temp_d;
    logic [7:0]        rdata_q, rdata_d;
    logic              srst_q, srst_d;
    idc_state_t        state_q, state_d;

    // dreq filter: synchroniser view and filtered level
    logic [NCH-1:0]    dreqAgree;
    logic [NCH-1:0]    dreqLevel;
    logic [NCH-1:0]    dreqF_q, dreqF_d;

    // ----------------------------------------------------------------
    // next-value logic
    // ----------------------------------------------------------------

    // controller-wide next values
    always_comb
    begin
        cmd_d   = cmd_q;
        bptr_d  = bptr_q;
        temp_d  = temp_q;
        srst_d  = wrClr;
        state_d = state_q;
        rdata_d = rdata_q;

        // command bits
        if (wrCmd)
            cmd_d = ioWdata[1:0];

        // byte flop: clear wins over a same-cycle toggle
        if (wordAccess)
            bptr_d = ~bptr_q;
        if (wrBptr)
            bptr_d = 1'b0;

        // last byte of a memory copy
        if (copyByteValid && cmd_q[`IDC_CMD_COPY_BIT])
            temp_d = copyByte;

        // engine busy tracking
        unique case (state_q)
            IDC_IDLE:   if (xferActive) state_d = IDC_ACTIVE;
            IDC_ACTIVE: if (!xferActive) state_d = IDC_IDLE;
        endcase

        // reads have no side effect; only the shared offset returns data
        if (ioRead)
            rdata_d = hit(ioAddr, `IDC_OFF_TEMP_CLR) ? temp_q : 8'h00;

        // master clear overrides anything else in the same cycle
        if (wrClr)
        begin
            cmd_d   = `IDC_RST_CMD;
            bptr_d  = 1'b0;
            temp_d  = `IDC_RST_TEMP;
            rdata_d = 8'h00;
            state_d = IDC_IDLE;
        end
    end

    // per-channel next values
    always_comb
    begin
        mask_d   = mask_q;
        req_d    = req_q;
        mode_d   = mode_q;
        dir_d    = dir_q;
        auto_d   = auto_q;
        xfer_d   = xfer_q;
        tvalid_d = tvalid_q;
        for (int i = 0; i < NCH; i++)
        begin
            // pin level is taken only once stages two and three agree
            dreqF_d[i] = dreqAgree[i] ? dreqLevel[i] : dreqF_q[i];
            if (wrReq && selOne[i])
                req_d[i] = ioWdata[`IDC_SETCLR_BIT];
            if (wrSmask && selOne[i])
                mask_d[i] = ioWdata[`IDC_SETCLR_BIT];
            if (wrMode && selOne[i])
            begin
                mode_d[i] = idc_mode_t'(ioWdata[7:6]);
                dir_d[i]  = ioWdata[`IDC_MODE_DIR_BIT];
                auto_d[i] = ioWdata[`IDC_MODE_AUTO_BIT];
                xfer_d[i] = idc_xfer_t'(ioWdata[3:2]);
            end
            // illegal code or cascade/copy leaves type meaningless
            tvalid_d[i] = (mode_d[i] != IDC_CASCADE) && !cmd_d[`IDC_CMD_COPY_BIT]
                          && (xfer_d[i] != IDC_ILLEGAL);
        end

        // whole-mask writes
        if (wrUnmask)
            mask_d = '0;
        if (wrAmask)
            mask_d = ioWdata[NCH-1:0];

        // pending follows the mask as it stands after this write
        pend_d = (req_d | dreqF_q) & ~mask_d;

        // master clear returns every channel to its reset state
        if (wrClr)
        begin
            mask_d   = `IDC_RST_MASK;
            dreqF_d  = '0;
            req_d    = `IDC_RST_REQ;
            pend_d   = '0;
            mode_d   = '{default: IDC_DEMAND};
            dir_d    = '0;
            auto_d   = '0;
            xfer_d   = '{default: IDC_VERIFY};
            tvalid_d = '0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_q    <= `IDC_RST_CMD;
            mask_q   <= `IDC_RST_MASK;
            req_q    <= `IDC_RST_REQ;
            pend_q   <= '0;
            mode_q   <= '{default: IDC_DEMAND};
            dir_q    <= '0;
            auto_q   <= '0;
            xfer_q   <= '{default: IDC_VERIFY};
            tvalid_q <= '0;
            bptr_q   <= 1'b0;
            temp_q   <= `IDC_RST_TEMP;
            rdata_q  <= 8'h00;
            srst_q   <= 1'b0;
            state_q  <= IDC_IDLE;
            dreqF_q  <= '0;
        end
        else
        begin
            cmd_q    <= cmd_d;
            mask_q   <= mask_d;
            req_q    <= req_d;
            pend_q   <= pend_d;
            mode_q   <= mode_d;
            dir_q    <= dir_d;
            auto_q   <= auto_d;
            xfer_q   <= xfer_d;
            tvalid_q <= tvalid_d;
            bptr_q   <= bptr_d;
            temp_q   <= temp_d;
            rdata_q  <= rdata_d;
            srst_q   <= srst_d;
            state_q  <= state_d;
            dreqF_q  <= dreqF_d;
        end
    end

    // ----------------------------------------------------------------
    // dreq pin synchronisers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gSync
            logic [2:0] stage_q;

            // three flops in a row; only stage two reads stage one
            always_ff @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    stage_q <= 3'h0;
                else
                    stage_q <= {stage_q[1:0], dreqIn[g]};
            end

            // a change counts once stages two and three agree
            assign dreqAgree[g] = (stage_q[1] == stage_q[2]);
            assign dreqLevel[g] = stage_q[2];
        end
    endgenerate

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // read data and command bits
    assign ioRdata          = rdata_q;
    assign memoryCopyEnable = cmd_q[`IDC_CMD_COPY_BIT];
    assign channel0AddrHold = cmd_q[`IDC_CMD_HOLD_BIT];

    // masks and requests
    assign channelBlock     = mask_q;
    assign softRequest      = req_q;
    assign requestPending   = pend_q;

    // per-channel mode
    assign chanMode         = mode_q;
    assign addressDirection = dir_q;
    assign autoInit         = auto_q;
    assign transferType     = xfer_q;
    assign typeValid        = tvalid_q;

    // byte flop, strobe and state
    assign highByteSel      = bptr_q;
    assign softResetStrobe  = srst_q;
    assign ctrlState        = state_q;

endmodule

`default_nettype wire

// ---- tb/idc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// register write and byte flop toggle checks
// ------------------------------------------------
module idc_props #(
    parameter int NCH = 4
) (
    input wire logic           core_clk,
    input wire logic           sys_rst,
    input wire logic           ioWrite,
    input wire logic [3:0]     ioAddr,
    input wire logic [7:0]     ioWdata,
    input wire logic           wordAccess,
    input wire logic           memoryCopyEnable,
    input wire logic           channel0AddrHold,
    input wire logic [NCH-1:0] channelBlock,
    input wire logic [NCH-1:0] softRequest,
    input wire logic           highByteSel,
    input wire logic           softResetStrobe,
    input wire logic           ctrlState
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_hold_bit: assert property (ioWrite && ioAddr == 4'h8 |=> channel0AddrHold == $past(ioWdata[1]))
        else $error("hold bit wrong");
    chk_copy_bit: assert property (ioWrite && ioAddr == 4'h8 |=> memoryCopyEnable == $past(ioWdata[0]))
        else $error("copy bit wrong");
    chk_soft_req: assert property (ioWrite && ioAddr == 4'h9 |=> softRequest[$past(ioWdata[1:0])] == $past(ioWdata[2]))
        else $error("request bit wrong");
    chk_single_mask: assert property (ioWrite && ioAddr == 4'ha |=> channelBlock[$past(ioWdata[1:0])] == $past(ioWdata[2]))
        else $error("single mask wrong");
    chk_unmask_all: assert property (ioWrite && ioAddr == 4'he |=> channelBlock == 4'h0)
        else $error("unmask failed");
    chk_mask_all: assert property (ioWrite && ioAddr == 4'hf |=> channelBlock == $past(ioWdata[3:0]))
        else $error("all mask wrong");
    chk_master_clear: assert property (ioWrite && ioAddr == 4'hd |=> channelBlock == 4'hf && !memoryCopyEnable)
        else $error("master clear wrong");
    chk_bptr_clear: assert property (ioWrite && ioAddr == 4'hc |=> !highByteSel)
        else $error("byte flop not cleared");
    chk_flop_toggle: assert property (wordAccess && !(ioWrite && ioAddr[3:1] == 3'h6) |=> $changed(highByteSel))
        else $error("byte flop not toggled");
    chk_clear_idle: assert property (ioWrite && ioAddr == 4'hd |=> !ctrlState)
        else $error("master clear left engine busy");
    chk_strobe_pulse: assert property (ioWrite && ioAddr == 4'hd |=> softResetStrobe)
        else $error("no soft reset strobe");
    chk_strobe_cause: assert property (softResetStrobe |-> $past(ioWrite) && $past(ioAddr) == 4'hd)
        else $error("stray soft reset strobe");
    cov_clear: cover property (ioWrite && ioAddr == 4'hd);
    cov_toggle: cover property (wordAccess ##2 wordAccess);
    cov_strobe: cover property (softResetStrobe);
endmodule
bind idc_channel_control idc_props #(.NCH(NCH)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWdata(ioWdata),
    .wordAccess(wordAccess), .memoryCopyEnable(memoryCopyEnable), .channel0AddrHold(channel0AddrHold),
    .channelBlock(channelBlock), .softRequest(softRequest), .highByteSel(highByteSel),
    .softResetStrobe(softResetStrobe), .ctrlState(ctrlState)
);
`default_nettype wire

// ---- tb/idc_periph.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// isa peripheral request model
// ------------------------------------------------
module idc_periph (
    input  wire logic       core_clk,
    input  wire logic [3:0] want,
    output logic      [3:0] dreq
);
    // request levels move only after the falling edge
    initial dreq = 4'h0;
    always @(negedge core_clk)
    begin
        dreq <= want;
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// channel control bench
// ------------------------------------------------
module tb_top;
    import idc_pkg::*;
    logic                  core_clk = 1'b0, sys_rst = 1'b1, ioWrite = 1'b0, ioRead = 1'b0;
    logic                  wordAccess = 1'b0, xferActive = 1'b0, copyByteValid = 1'b0;
    logic      [3:0]       ioAddr = 4'h0, want = 4'h0, dreq, m, s, channelBlock, softRequest, requestPending;
    logic      [7:0]       ioWdata = 8'h00, copyByte = 8'h00, ioRdata, d;
    logic      [3:0]       addressDirection, autoInit, typeValid;
    logic                  memoryCopyEnable, channel0AddrHold, highByteSel, softResetStrobe, c;
    idc_mode_t [3:0]       chanMode;
    idc_xfer_t [3:0]       transferType;
    idc_state_t            ctrlState;
    int                    badCount = 0, checksDone = 0;
    always #12.5 core_clk = ~core_clk;
    idc_periph u_periph (.core_clk(core_clk), .want(want), .dreq(dreq));
    idc_channel_control #(.NCH(4)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr),
        .ioWdata(ioWdata), .wordAccess(wordAccess), .xferActive(xferActive), .copyByteValid(copyByteValid),
        .copyByte(copyByte), .dreqIn(dreq), .ioRdata(ioRdata), .memoryCopyEnable(memoryCopyEnable),
        .channel0AddrHold(channel0AddrHold), .channelBlock(channelBlock), .softRequest(softRequest),
        .requestPending(requestPending), .chanMode(chanMode), .addressDirection(addressDirection),
        .autoInit(autoInit), .transferType(transferType), .typeValid(typeValid), .highByteSel(highByteSel),
        .softResetStrobe(softResetStrobe), .ctrlState(ctrlState)
    );
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checksDone++;
        if (g !== e)
        begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one-cycle strobe, then a settle cycle before any check
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
        ioAddr = a;
        ioWdata = v;
        ioWrite = w;
        ioRead = !w;
        @(negedge core_clk);
        ioWrite = 1'b0;
        ioRead = 1'b0;
        @(negedge core_clk);
    endtask
    function automatic logic tv(input logic [1:0] md, input logic [1:0] xt, input logic cp);
        return md != 2'b11 && xt != 2'b11 && !cp;
    endfunction
    task automatic end_sim;
        $display("checks=%0d bad=%0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (4000) @(posedge core_clk);
        badCount++;
        end_sim;
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h426e));
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
        chk({channelBlock, softRequest}, 8'hf0);
        s = 4'h0;
        m = 4'hf;
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, 4'h8, {6'($urandom), 2'(i)});
            chk({6'h0, channel0AddrHold, memoryCopyEnable}, 8'(i));
        end
        for (int i = 0; i < 16; i++)
        begin
            d = 8'($urandom);
            acc(1'b1, 4'h9, d);
            s[d[1:0]] = d[2];
            chk(8'(softRequest), 8'(s));
            d = 8'($urandom);
            acc(1'b1, 4'ha, d);
            m[d[1:0]] = d[2];
            chk(8'(channelBlock), 8'(m));
        end
        want = 4'($urandom);
        d = 8'($urandom);
        acc(1'b1, 4'hf, d);
        m = d[3:0];
        chk(8'(channelBlock), 8'(m));
        repeat (5) @(negedge core_clk);
        chk(8'(requestPending), 8'((s | want) & ~m));
        acc(1'b1, 4'he, 8'($urandom));
        chk({channelBlock, requestPending}, {4'h0, s | want});
        for (int i = 0; i < 32; i++)
        begin
            c = i[4];
            acc(1'b1, 4'h8, 8'(c));
            d = {i[3:2], 2'($urandom), i[1:0], 2'($urandom)};
            acc(1'b1, 4'hb, d);
            chk({chanMode[d[1:0]], addressDirection[d[1:0]], autoInit[d[1:0]], 3'h0, typeValid[d[1:0]]},
                {d[7:4], 3'h0, tv(d[7:6], d[3:2], c)});
            if (tv(d[7:6], d[3:2], c))
                chk(8'(transferType[d[1:0]]), 8'(d[3:2]));
        end
        acc(1'b1, 4'hc, 8'($urandom));
        chk(8'(highByteSel), 8'h00);
        for (int i = 1; i < 6; i++)
        begin
            wordAccess = 1'b1;
            @(negedge core_clk);
            wordAccess = 1'b0;
            @(negedge core_clk);
            chk(8'(highByteSel), 8'(i % 2));
        end
        d = 8'($urandom);
        copyByte = d;
        copyByteValid = 1'b1;
        xferActive = 1'b1;
        @(negedge core_clk);
        copyByteValid = 1'b0;
        copyByte = ~d;
        @(negedge core_clk);
        chk(8'(ctrlState), 8'h01);
        acc(1'b0, 4'hd, 8'h00);
        chk(ioRdata, d);
        chk(8'(channelBlock), 8'h00);
        acc(1'b0, 4'h3, 8'h00);
        chk(ioRdata, 8'h00);
        // master clear while the engine is busy must drop it to idle
        acc(1'b1, 4'hd, 8'($urandom));
        xferActive = 1'b0;
        @(negedge core_clk);
        chk({channelBlock, softRequest}, 8'hf0);
        chk({memoryCopyEnable, channel0AddrHold, highByteSel, ctrlState, 4'h0}, 8'h00);
        acc(1'b0, 4'hd, 8'h00);
        chk(ioRdata, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
